/* File: pkg/smmc_pkg.sv */
// Package for the serial module mode controller: register map, field
// layouts, reset values, timing constants and the state types.
// Assumes a 100 MHz core clock and a 32-bit Avalon-MM register bus.
package smmc_pkg;

    // ==================================================================
    // Timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int BAUD_DEFAULT    = 9600;
    localparam int BIT_CYCLES      = CLK_HZ / BAUD_DEFAULT;
    localparam int FRAME_BITS      = 10;                   // Start, 8 data, 1 stop
    localparam int BREAK_CYCLES    = BIT_CYCLES * (FRAME_BITS + 1);
    localparam int CONNECT_TRIES   = 3;
    localparam int PEER_SLOTS      = 3;

    // ==================================================================
    // Register offsets (byte addresses)
    localparam logic [5:0] REG_CTRL    = 6'h00;
    localparam logic [5:0] REG_STATUS  = 6'h04;
    localparam logic [5:0] REG_IRQSTAT = 6'h08;
    localparam logic [5:0] REG_IRQMASK = 6'h0C;
    localparam logic [5:0] REG_EVENT   = 6'h10;
    localparam logic [5:0] REG_BAUDDIV = 6'h14;

    // ==================================================================
    // Control register fields
    localparam int CTRL_CMD_MODE   = 0;    // 1 = command mode, 0 = automatic
    localparam int CTRL_FORCE_MST  = 1;
    localparam int CTRL_FILT_LO    = 2;    // Two-bit event filter level
    localparam int CTRL_RECONNECT  = 4;    // Write 1: connect stored peers

    // Filter levels
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_STD  = 2'h1;
    localparam logic [1:0] FILT_ALL  = 2'h2;

    // Interrupt bits
    localparam int IRQ_EVENT   = 0;
    localparam int IRQ_BREAK   = 1;
    localparam int IRQ_LINKUP  = 2;
    localparam int IRQ_REFUSED = 3;
    localparam int IRQ_BITS    = 4;

    // Event codes delivered to the host
    localparam logic [3:0] EV_PORT_OPEN  = 4'h1;
    localparam logic [3:0] EV_LINK_OK    = 4'h2;
    localparam logic [3:0] EV_LINK_FAIL  = 4'h3;
    localparam logic [3:0] EV_CMD_DONE   = 4'h4;
    localparam logic [3:0] EV_PHY_CHANGE = 4'h5;

    // Reset values
    localparam logic [1:0]  FILT_RESET    = FILT_STD;
    localparam logic [15:0] BAUDDIV_RESET = 16'(BIT_CYCLES);

    // ==================================================================
    // Types
    typedef enum logic [2:0] {
        ST_LOAD, ST_IDLE, ST_DIAL, ST_WAIT, ST_PASS
    } smmc_state_t;

    typedef struct packed {
        logic       cmdMode;
        logic       forceMaster;
        logic [1:0] filter;
        logic [15:0] baudDiv;
    } smmc_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] code;
        logic [3:0] arg;
    } smmc_event_t;

endpackage

/* File: hdl/smmc_mode_ctrl.sv */
// Mode controller of a serial radio module: operation mode, pass-through,
// stored-peer auto connect, event filter and host break detection.
// Assumes nonvolatile_store answers loads, and a radio link engine outside.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module smmc_mode_ctrl #(
    parameter int BREAK_LEN = smmc_pkg::BREAK_CYCLES   // Break length in cycles
) (
    input  wire logic        core_clk,        // 100 MHz clock
    input  wire logic        arst_n,          // Async reset, active low
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,     // Byte address
    input  wire logic        avs_read,        // Read strobe
    input  wire logic        avs_write,       // Write strobe
    input  wire logic [31:0] avs_writedata,   // Write data
    output logic      [31:0] avs_readdata,    // Read data
    output logic             avs_waitrequest, // Stall
    output logic             irq,             // Level interrupt
    // Nonvolatile store
    output logic             nvsLoadReq,      // Load request
    input  wire logic        nvsLoadDone,     // Load done pulse
    input  wire logic        nvsCmdMode,      // Stored mode, 0 = automatic
    input  wire logic [1:0]  nvsPeerCount,    // Stored peers 0..3
    input  wire logic [1:0]  nvsFilter,       // Stored filter level
    // Radio link engine
    output logic             connectable,     // Page scan enabled
    output logic             discoverable,    // Inquiry scan enabled
    output logic             dialReq,         // Dial stored peer pulse
    output logic      [1:0]  dialSlot,        // Peer slot being dialled
    input  wire logic        dialDone,        // Dial finished pulse
    input  wire logic        dialOk,          // Dial succeeded
    input  wire logic        inLinkReq,       // Incoming link request pulse
    input  wire logic        inRoleSwitchOk,  // Peer agrees to role switch
    input  wire logic [3:0]  inLinkPort,      // Emulated port of request
    output logic             inLinkAccept,    // Accept pulse
    output logic             inLinkRefuse,    // Refuse pulse
    input  wire logic [1:0]  linkCount,       // Active links
    input  wire logic        phyChange,       // Physical layer change pulse
    // Host UART
    input  wire logic        uartRxPin,       // Raw host receive line
    input  wire logic        rxByteValid,     // Received byte pulse
    input  wire logic [7:0]  rxByte,          // Received byte
    input  wire logic        cmdDone,         // Host command completed pulse
    output logic             cmdByteValid,    // Byte to command parser
    output logic             linkByteValid,   // Byte to radio link
    output logic      [7:0]  fwdByte,         // Forwarded byte
    output logic             passThrough      // Pass-through active
);

    // ==================================================================
    // State
    typedef struct packed {
        smmc_pkg::smmc_state_t st;
        smmc_pkg::smmc_cfg_t   cfg;
        logic [1:0]            slot;
        logic [1:0]            tries;
        logic [1:0]            peers;
        logic [3:0]            irqStat;
        logic [3:0]            irqMask;
        smmc_pkg::smmc_event_t ev;
        logic [2:0]            rxSync;
        logic [31:0]           lowCnt;
        logic                  brk;
        logic                  dial;
        logic                  acc;
        logic                  ref_;
        logic                  cmdV;
        logic                  lnkV;
        logic [7:0]            fwd;
        logic [31:0]           rdata;
        logic                  rdv;
    } smmc_regs_t;

    smmc_regs_t r;
    smmc_regs_t next_r;

    logic access;

    // Event post: filter level decides whether it reaches the host
    function automatic logic passes(input logic [1:0] f, input logic [3:0] c);
        passes = (f == smmc_pkg::FILT_ALL) ||
                 ((f == smmc_pkg::FILT_STD) && (c != smmc_pkg::EV_PHY_CHANGE));
    endfunction

    // ==================================================================
    // Next-state logic
    always_comb begin
        logic [3:0] evSet;
        logic       post;
        logic [3:0] pCode;
        logic [3:0] pArg;
        evSet = 4'h0;
        post  = 1'b0;
        pCode = 4'h0;
        pArg  = 4'h0;
        next_r = r;
        next_r.dial = 1'b0;
        next_r.acc  = 1'b0;
        next_r.ref_ = 1'b0;
        next_r.cmdV = 1'b0;
        next_r.lnkV = 1'b0;
        next_r.rdv  = 1'b0;
        access = 1'b0;

        // Break detector on a three-stage synchronised line
        next_r.rxSync = {r.rxSync[1:0], uartRxPin};
        if (r.rxSync[2] == r.rxSync[1] && r.rxSync[2]) begin
            next_r.lowCnt = 32'h0;
            next_r.brk    = 1'b0;
        end else if (r.rxSync[2] == r.rxSync[1] && !r.rxSync[2]) begin
            if (r.lowCnt < 32'(BREAK_LEN)) begin
                next_r.lowCnt = r.lowCnt + 32'h1;
            end
        end
        if (r.lowCnt == 32'(BREAK_LEN) - 32'h1 && !r.brk) begin
            next_r.brk = 1'b1;
            evSet[smmc_pkg::IRQ_BREAK] = 1'b1;
        end

        // Byte routing: pass-through sends bytes raw to the link
        if (rxByteValid) begin
            next_r.fwd = rxByte;
            if (r.st == smmc_pkg::ST_PASS) begin
                next_r.lnkV = 1'b1;
            end else if (r.st != smmc_pkg::ST_LOAD) begin
                next_r.cmdV = 1'b1;
            end
        end

        if (cmdDone) begin
            post = 1'b1;
            pCode = smmc_pkg::EV_CMD_DONE;
        end
        if (phyChange) begin
            post = 1'b1;
            pCode = smmc_pkg::EV_PHY_CHANGE;
        end

        // Incoming links
        if (inLinkReq && r.st != smmc_pkg::ST_LOAD) begin
            if (r.st == smmc_pkg::ST_PASS ||
                (r.cfg.forceMaster && !inRoleSwitchOk)) begin
                next_r.ref_ = 1'b1;
                evSet[smmc_pkg::IRQ_REFUSED] = 1'b1;
            end else begin
                next_r.acc = 1'b1;
                evSet[smmc_pkg::IRQ_LINKUP] = 1'b1;
                post  = 1'b1;
                pCode = smmc_pkg::EV_PORT_OPEN;
                pArg  = inLinkPort;
                if (!r.cfg.cmdMode && linkCount == 2'h0) begin
                    next_r.st = smmc_pkg::ST_PASS;
                end
            end
        end

        case (r.st)
            smmc_pkg::ST_LOAD: begin
                if (nvsLoadDone) begin
                    next_r.cfg.cmdMode = nvsCmdMode;
                    next_r.cfg.filter  = nvsFilter;
                    next_r.peers = (nvsPeerCount > 2'(smmc_pkg::PEER_SLOTS)) ?
                                   2'(smmc_pkg::PEER_SLOTS) : nvsPeerCount;
                    next_r.slot  = 2'h0;
                    next_r.tries = 2'h0;
                    if (!nvsCmdMode && nvsPeerCount != 2'h0) begin
                        next_r.st = smmc_pkg::ST_DIAL;
                    end else begin
                        next_r.st = smmc_pkg::ST_IDLE;
                    end
                end
            end
            smmc_pkg::ST_DIAL: begin
                if (next_r.st == smmc_pkg::ST_DIAL) begin
                    next_r.dial = 1'b1;
                    next_r.st   = smmc_pkg::ST_WAIT;
                end
            end
            smmc_pkg::ST_WAIT: begin
                if (dialDone && next_r.st == smmc_pkg::ST_WAIT) begin
                    post  = 1'b1;
                    pCode = dialOk ? smmc_pkg::EV_LINK_OK : smmc_pkg::EV_LINK_FAIL;
                    pArg  = {2'h0, r.slot};
                    if (dialOk || r.tries == 2'(smmc_pkg::CONNECT_TRIES - 1)) begin
                        next_r.tries = 2'h0;
                        next_r.slot  = r.slot + 2'h1;
                        next_r.st    = (r.slot + 2'h1 >= r.peers) ?
                                       smmc_pkg::ST_IDLE : smmc_pkg::ST_DIAL;
                    end else begin
                        next_r.tries = r.tries + 2'h1;
                        next_r.st    = smmc_pkg::ST_DIAL;
                    end
                end
            end
            smmc_pkg::ST_PASS: begin
                if ((!r.brk && next_r.brk) || linkCount > 2'h1) begin
                    next_r.st = smmc_pkg::ST_IDLE;
                end
            end
            smmc_pkg::ST_IDLE: begin
            end
            default: next_r.st = smmc_pkg::ST_IDLE;
        endcase

        // Register access, answered in one cycle
        access = (avs_read || avs_write) && !r.rdv;
        if (access && avs_write) begin
            case (avs_address)
                smmc_pkg::REG_CTRL: begin
                    next_r.cfg.cmdMode     = avs_writedata[smmc_pkg::CTRL_CMD_MODE];
                    next_r.cfg.forceMaster = avs_writedata[smmc_pkg::CTRL_FORCE_MST];
                    next_r.cfg.filter      = avs_writedata[smmc_pkg::CTRL_FILT_LO +: 2];
                    if (avs_writedata[smmc_pkg::CTRL_RECONNECT] && r.peers != 2'h0 &&
                        next_r.st == smmc_pkg::ST_IDLE) begin
                        next_r.slot  = 2'h0;
                        next_r.tries = 2'h0;
                        next_r.st    = smmc_pkg::ST_DIAL;
                    end
                end
                smmc_pkg::REG_IRQSTAT: next_r.irqStat = r.irqStat & ~avs_writedata[3:0];
                smmc_pkg::REG_IRQMASK: next_r.irqMask = avs_writedata[3:0];
                smmc_pkg::REG_EVENT:   next_r.ev.valid = 1'b0;
                smmc_pkg::REG_BAUDDIV: next_r.cfg.baudDiv = avs_writedata[15:0];
                default: ;
            endcase
        end
        // Event post after the host's clear, so a clear in the same cycle never drops a fresh event
        if (post && passes(r.cfg.filter, pCode)) begin
            next_r.ev = '{valid: 1'b1, code: pCode, arg: pArg};
            evSet[smmc_pkg::IRQ_EVENT] = 1'b1;
        end
        if (access && avs_read) begin
            next_r.rdv = 1'b1;
            case (avs_address)
                smmc_pkg::REG_CTRL:    next_r.rdata = {26'h0, 2'h0, r.cfg.filter,
                                                       r.cfg.forceMaster, r.cfg.cmdMode};
                smmc_pkg::REG_STATUS:  next_r.rdata = {22'h0, r.peers, r.slot, linkCount,
                                                       r.brk, 2'h0, 1'(r.st == smmc_pkg::ST_PASS)};
                smmc_pkg::REG_IRQSTAT: next_r.rdata = {28'h0, r.irqStat};
                smmc_pkg::REG_IRQMASK: next_r.rdata = {28'h0, r.irqMask};
                smmc_pkg::REG_EVENT:   next_r.rdata = {23'h0, r.ev};
                smmc_pkg::REG_BAUDDIV: next_r.rdata = {16'h0, r.cfg.baudDiv};
                default:               next_r.rdata = 32'h0;
            endcase
        end
        // Set wins over clear
        next_r.irqStat = next_r.irqStat | evSet;
    end

    // ==================================================================
    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.st <= smmc_pkg::ST_LOAD;
            r.cfg.filter <= smmc_pkg::FILT_RESET;
            r.cfg.baudDiv <= smmc_pkg::BAUDDIV_RESET;
            r.cfg.cmdMode <= 1'b0;
            r.rxSync <= 3'h7;
        end else begin
            r <= next_r;
        end
    end

    // Outputs
    assign avs_readdata    = r.rdata;
    assign avs_waitrequest = (avs_read && !r.rdv);
    assign irq             = |(r.irqStat & r.irqMask);
    assign nvsLoadReq      = (r.st == smmc_pkg::ST_LOAD);
    assign connectable     = (r.st != smmc_pkg::ST_LOAD) && (r.st != smmc_pkg::ST_PASS);
    assign discoverable    = connectable;
    assign dialReq         = r.dial;
    assign dialSlot        = r.slot;
    assign inLinkAccept    = r.acc;
    assign inLinkRefuse    = r.ref_;
    assign cmdByteValid    = r.cmdV;
    assign linkByteValid   = r.lnkV;
    assign fwdByte         = r.fwd;
    assign passThrough     = (r.st == smmc_pkg::ST_PASS);

endmodule // smmc_mode_ctrl

`default_nettype wire

/* File: dv/smmc_mode_ctrl_asserts.sv */
// Checker for the mode controller, watching the top module's ports.
// Assumes one clock domain and is bound onto smmc_mode_ctrl below.
`timescale 1ns/1ps
`default_nettype none
module smmc_mode_ctrl_asserts (
    input wire logic       core_clk,        // Clock
    input wire logic       arst_n,          // Async reset, active low
    input wire logic       avs_read,        // Read strobe
    input wire logic       avs_write,       // Write strobe
    input wire logic       avs_waitrequest, // Stall
    input wire logic       nvsLoadReq,      // Load in progress
    input wire logic       connectable,     // Page scan
    input wire logic       discoverable,    // Inquiry scan
    input wire logic       dialReq,         // Dial pulse
    input wire logic       inLinkReq,       // Incoming request
    input wire logic       inLinkAccept,    // Accept pulse
    input wire logic       inLinkRefuse,    // Refuse pulse
    input wire logic [1:0] linkCount,       // Active links
    input wire logic       rxByteValid,     // Host byte strobe
    input wire logic [7:0] rxByte,          // Host byte
    input wire logic       cmdByteValid,    // Byte to parser
    input wire logic       linkByteValid,   // Byte to link
    input wire logic [7:0] fwdByte,         // Forwarded byte
    input wire logic       passThrough      // Pass-through active
);
    // ====================
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_rdwait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_rdwait: assert property (p_rdwait) else $error("read wait not one cycle");
    property p_wrnowait; avs_write |-> !avs_waitrequest; endproperty
    a_wrnowait: assert property (p_wrnowait) else $error("write stalled");
    property p_fwd; rxByteValid && passThrough |=> linkByteValid && !cmdByteValid
        && fwdByte == $past(rxByte); endproperty
    a_fwd: assert property (p_fwd) else $error("byte not forwarded");
    property p_cmd; rxByteValid && !passThrough && !nvsLoadReq |=> cmdByteValid
        && !linkByteValid; endproperty
    a_cmd: assert property (p_cmd) else $error("byte not parsed");
    property p_load; nvsLoadReq |-> !connectable && !passThrough && !dialReq; endproperty
    a_load: assert property (p_load) else $error("active while loading");
    property p_scan; passThrough |-> !connectable && !discoverable; endproperty
    a_scan: assert property (p_scan) else $error("scanning in pass-through");
    property p_multi; linkCount > 2'h1 |=> !passThrough; endproperty
    a_multi: assert property (p_multi) else $error("pass-through with links");
    property p_busy; inLinkReq && passThrough |=> inLinkRefuse && !inLinkAccept; endproperty
    a_busy: assert property (p_busy) else $error("link taken in pass");
    property p_ans; inLinkReq |=> inLinkAccept != inLinkRefuse; endproperty
    a_ans: assert property (p_ans) else $error("link request unanswered");
endmodule // smmc_mode_ctrl_asserts

bind smmc_mode_ctrl smmc_mode_ctrl_asserts u_chk (.core_clk, .arst_n, .avs_read, .avs_write,
    .avs_waitrequest, .nvsLoadReq, .connectable, .discoverable, .dialReq, .inLinkReq,
    .inLinkAccept, .inLinkRefuse, .linkCount, .rxByteValid, .rxByte, .cmdByteValid,
    .linkByteValid, .fwdByte, .passThrough);
`default_nettype wire

/* File: dv/smmc_host_model.sv */
// Host model on the UART side: byte strobes and break conditions.
// Assumes the bench requests bytes and breaks one edge at a time.
`timescale 1ns/1ps
`default_nettype none
module smmc_host_model (
    input  wire logic       core_clk,    // Clock
    input  wire logic       sendReq,     // Send one byte
    input  wire logic [7:0] sendData,    // Byte to send
    input  wire logic       breakReq,    // Start a break
    input  wire logic [7:0] breakLen,    // Break length in cycles
    output logic            uartRxPin,   // Line, idles high
    output logic            rxByteValid, // Byte strobe
    output logic      [7:0] rxByte       // Byte, scrambled when idle
);
    int lowCnt = 0;
    initial rxByteValid = 1'b0;
    initial rxByte = 8'h00;
    // Byte strobe and break timer
    always @(posedge core_clk) begin
        rxByteValid <= sendReq;
        rxByte <= sendReq ? sendData : ~rxByte;
        if (breakReq)
            lowCnt <= int'(breakLen);
        else if (lowCnt != 0)
            lowCnt <= lowCnt - 1;
    end
    assign uartRxPin = (lowCnt == 0);
endmodule // smmc_host_model
`default_nettype wire

/* File: dv/smmc_mode_ctrl_tb.sv */
// Testbench for the mode controller: bus tasks and ordered scenarios.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module smmc_mode_ctrl_tb;
    logic core_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
    logic nvsLoadDone = 1'b0, nvsCmdMode = 1'b0, dialDone = 1'b0, dialOk = 1'b0, cmdDone = 1'b0;
    logic inLinkReq = 1'b0, inRoleSwitchOk = 1'b0, phyChange = 1'b0, hSend = 1'b0;
    logic hBreak = 1'b0, avs_waitrequest, irq, nvsLoadReq, connectable, discoverable;
    logic dialReq, inLinkAccept, inLinkRefuse, cmdByteValid, linkByteValid, passThrough;
    logic uartRxPin, rxByteValid;
    logic [1:0] nvsPeerCount = 2'h0, nvsFilter = 2'h1, linkCount = 2'h0, dialSlot;
    logic [3:0] inLinkPort = 4'h3;
    logic [7:0] rxByte, fwdByte, hData = 8'h00, hLen = 8'h00;
    int err_total = 0, checked = 0, cyc = 0, accCnt = 0, refCnt = 0, dialCnt = 0;
    int linkCnt = 0, cmdCnt = 0, slotSum = 0, n;

    smmc_mode_ctrl #(.BREAK_LEN(50)) u_dut (.core_clk, .arst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .nvsLoadReq,
        .nvsLoadDone, .nvsCmdMode, .nvsPeerCount, .nvsFilter, .connectable, .discoverable,
        .dialReq, .dialSlot, .dialDone, .dialOk, .inLinkReq, .inRoleSwitchOk, .inLinkPort,
        .inLinkAccept, .inLinkRefuse, .linkCount, .phyChange, .uartRxPin, .rxByteValid,
        .rxByte, .cmdDone, .cmdByteValid, .linkByteValid, .fwdByte, .passThrough);
    smmc_host_model u_host (.core_clk, .sendReq(hSend), .sendData(hData), .breakReq(hBreak),
        .breakLen(hLen), .uartRxPin, .rxByteValid, .rxByte);

    // ====================
    // Clock, pulse counters, dial responder and timeout
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (inLinkAccept === 1'b1) accCnt++;
        if (inLinkRefuse === 1'b1) refCnt++;
        if (linkByteValid === 1'b1) linkCnt++;
        if (cmdByteValid === 1'b1) cmdCnt++;
        dialDone <= (dialReq === 1'b1);
        if (dialReq === 1'b1) begin
            dialCnt++;
            slotSum += int'(dialSlot);
        end
        dialOk <= (dialCnt == 3);
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // ====================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        // Stall and read data are taken at the same rising edge
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        chk(d & m, e);
    endtask
    task automatic link(input logic rs);
        @(posedge core_clk);
        inLinkReq <= 1'b1;
        inRoleSwitchOk <= rs;
        @(posedge core_clk);
        inLinkReq <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic host(input logic brk, input logic [7:0] v);
        @(posedge core_clk);
        hSend <= !brk;
        hBreak <= brk;
        hData <= v;
        hLen <= v;
        @(posedge core_clk);
        hSend <= 1'b0;
        hBreak <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic ev(input logic phy);
        wr(smmc_pkg::REG_EVENT, 32'h0);
        @(posedge core_clk);
        phyChange <= phy;
        cmdDone <= !phy;
        @(posedge core_clk);
        phyChange <= 1'b0;
        cmdDone <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic boot(input logic mode, input logic [1:0] peers);
        @(posedge core_clk);
        arst_n <= 1'b0;
        nvsCmdMode <= mode;
        nvsPeerCount <= peers;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1; // Released after 12 cycles in reset
        @(negedge core_clk);
        chk(32'(nvsLoadReq), 32'h1);
        @(posedge core_clk);
        nvsLoadDone <= 1'b1;
        @(posedge core_clk);
        nvsLoadDone <= 1'b0;
        repeat (100) @(posedge core_clk);
    endtask
    task automatic finish_test();
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ====================
    // Scenarios in order
    initial begin
        boot(1'b0, 2'h1);
        chk(dialCnt, 3);
        rc(smmc_pkg::REG_EVENT, 32'h1F0, 32'h120);
        rc(smmc_pkg::REG_CTRL, 32'hF, 32'h4);
        rc(smmc_pkg::REG_BAUDDIV, 32'hFFFF, 32'(smmc_pkg::BIT_CYCLES));
        rc(6'h3C, 32'hFFFFFFFF, 32'h0);
        chk({connectable, discoverable, passThrough}, 3'h6);
        wr(smmc_pkg::REG_IRQMASK, 32'h1);
        wr(smmc_pkg::REG_IRQSTAT, 32'hF);
        wr(smmc_pkg::REG_EVENT, 32'h0);
        link(1'b1);
        chk({passThrough, irq, 30'(accCnt)}, 32'hC0000001);
        rc(smmc_pkg::REG_EVENT, 32'h1FF, 32'h113);
        host(1'b0, 8'hA5);
        chk({fwdByte, 12'(linkCnt), 12'(cmdCnt)}, 32'hA5001000);
        link(1'b1);
        chk(refCnt, 1);
        host(1'b1, 8'h14);
        repeat (40) @(posedge core_clk);
        chk(32'(passThrough), 32'h1);
        host(1'b1, 8'h3C);
        n = 0;
        while (passThrough === 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        rc(smmc_pkg::REG_IRQSTAT, 32'h2, 32'h2);
        host(1'b0, 8'h5A);
        chk({passThrough, 31'(cmdCnt)}, 32'h1);
        wr(smmc_pkg::REG_CTRL, 32'h5);
        link(1'b1);
        chk({passThrough, 31'(accCnt)}, 32'h2);
        wr(smmc_pkg::REG_CTRL, 32'h6);
        link(1'b0);
        chk(refCnt, 2);
        linkCount <= 2'h1;
        link(1'b1);
        chk({passThrough, 31'(accCnt)}, 32'h3);
        linkCount <= 2'h0;
        wr(smmc_pkg::REG_CTRL, 32'h8);
        link(1'b1);
        chk({passThrough, 31'(accCnt)}, 32'h80000004);
        linkCount <= 2'h2;
        repeat (3) @(posedge core_clk);
        chk(32'(passThrough), 32'h0);
        linkCount <= 2'h0;
        ev(1'b1);
        rc(smmc_pkg::REG_EVENT, 32'h1F0, 32'h150);
        wr(smmc_pkg::REG_CTRL, 32'h4);
        ev(1'b1);
        rc(smmc_pkg::REG_EVENT, 32'h100, 32'h0);
        ev(1'b0);
        rc(smmc_pkg::REG_EVENT, 32'h1F0, 32'h140);
        wr(smmc_pkg::REG_CTRL, 32'h0);
        ev(1'b0);
        rc(smmc_pkg::REG_EVENT, 32'h100, 32'h0);
        boot(1'b1, 2'h3);
        chk(dialCnt, 3);
        wr(smmc_pkg::REG_CTRL, 32'h11);
        repeat (300) @(posedge core_clk);
        chk(dialCnt, 12);
        chk(slotSum, 9);
        rc(smmc_pkg::REG_STATUS, 32'h3FF, 32'h3C0);
        finish_test();
    end
endmodule // smmc_mode_ctrl_tb
`default_nettype wire
